//--- logic/isc_pkg.sv
// Purpose: shared constants and carrier types of the i2c slave front end
// Assumes: 100 MHz core clock, bus lines sampled by the core clock
// Notes: mode field bit 0 selects 10-bit addressing, bit 1 start/stop irqs
package isc_pkg;

    // bit counter values inside one 9-pulse segment
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // counter value after a start; the scl fall that closes the start wraps it to zero
    localparam logic [3:0] CNT_AFTER_START = 4'hF;
    // high address byte prefix for 10-bit addressing
    localparam logic [4:0] HI10_PREFIX = 5'h1E;
    // address compare ignores the direction bit
    localparam logic [7:0] RW_IGNORE = 8'hFE;
    localparam int MODE_TEN_POS = 0;
    localparam int MODE_SS_POS = 1;
    // reset values of synchronisers: bus idles high, reset starts asserted
    localparam logic [1:0] LINES_IDLE = 2'h3;
    localparam logic RST_ASSERTED = 1'b0;

    typedef enum logic [2:0] {PH_IDLE, PH_ADDR_HI, PH_ADDR_LO, PH_DATA, PH_READ} isc_phase_t;

    // configuration written by software, same clock domain
    typedef struct packed {
        logic [1:0] mode_select_field;
        logic start_irq_enable;
        logic stop_irq_enable;
        logic address_hold_enable;
        logic data_hold_enable;
        logic buffer_overwrite_enable;
        logic stretch_enable;
        logic ack_data_bit;
        logic [7:0] slave_address_reg;
        logic [7:0] address_mask;
    } isc_ctrl_t;

    // one-cycle software actions
    typedef struct packed {
        logic irq_clear;
        logic buffer_read;
        logic overflow_clear;
        logic clock_release_set;
        logic address_write;
    } isc_sw_t;

    typedef struct packed {
        logic [7:0] receive_buffer;
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic port_interrupt_flag;
        logic ack_status_bit;
        logic ack_time_status;
        logic update_address_flag;
        logic start_seen;
        logic stop_seen;
        logic rw_status;
        logic clock_release_bit;
    } isc_stat_t;

    // bus events found by the condition detector, one-cycle pulses
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } isc_cond_t;

    typedef struct packed {
        logic scl_q;
        logic sda_q;
        logic low_seen;
        isc_cond_t ev;
    } isc_det_st_t;

    typedef struct packed {
        isc_phase_t phase;
        isc_phase_t pend;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic ack_low;
        logic soft_ack;
        logic forced_nack;
        logic prior_match;
        isc_stat_t stat;
        logic sda_oe_n;
        logic scl_oe_n;
    } isc_st_t;

    localparam isc_stat_t STAT_RESET = '{clock_release_bit: 1'b1, default: '0};
    localparam isc_det_st_t DET_RESET = '{scl_q: 1'b1, sda_q: 1'b1, default: '0};
    localparam isc_st_t ST_RESET = '{phase: PH_IDLE, pend: PH_IDLE, stat: STAT_RESET,
        sda_oe_n: 1'b1, scl_oe_n: 1'b1, default: '0};

endpackage : isc_pkg

//--- logic/isc_sync.sv
// Purpose: two-flop synchroniser, also used to release the reset
// Assumes: din may change at any time relative to clk
// Notes: the first stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none
module isc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    // two stages, reset to a constant only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : isc_sync
`default_nettype wire

//--- logic/isc_cond.sv
// Purpose: finds start, stop and scl edges on the synchronised bus lines
// Assumes: scl_s and sda_s already passed two flops
// Notes: outputs are registered one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module isc_cond (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_s,
    input wire logic sda_s,
    output isc_pkg::isc_cond_t ev
);
    isc_pkg::isc_det_st_t st_r;
    isc_pkg::isc_det_st_t st_nxt;

    // sda moves while scl stays high mark the bus conditions
    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_q = scl_s;
        st_nxt.sda_q = sda_s;
        st_nxt.ev.rise = !st_r.scl_q && scl_s;
        st_nxt.ev.fall = st_r.scl_q && !scl_s;
        st_nxt.ev.start = st_r.scl_q && scl_s && st_r.sda_q && !sda_s;
        // a stop needs a low scl period since the last start
        st_nxt.ev.stop = st_r.scl_q && scl_s && !st_r.sda_q && sda_s && st_r.low_seen;
        if (st_nxt.ev.start) begin
            st_nxt.low_seen = 1'b0;
        end else if (!scl_s) begin
            st_nxt.low_seen = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= isc_pkg::DET_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ev = st_r.ev;

    AST_STOP_AFTER_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st_r.ev.stop) |-> $past(st_r.low_seen) && $past(st_r.scl_q, 2))
        else $error("stop flagged without a low scl period");
endmodule : isc_cond
`default_nettype wire

//--- logic/isc_slave.sv
// Purpose: i2c slave conditions, address match, byte reception and ack
// Assumes: control and software pulses come from the clk domain
// Notes: slave transmission data path is not part of this block
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - stop is sda rising while scl high
// - stop valid only after scl low since start
// - restart resets slave like a start
// - 10-bit read via restart holds scl
// - prior-match flag after full 10-bit write match
// - start/stop irq enables add irqs elsewhere
// - ninth pulse is ack, receiver pulls low
// - ack level stored in ack status bit
// - auto ack unless hold enables set
// - nack on overflow, or on full buffer unless overwrite enabled
// - ack time bit after eighth fall, holds only
// - mode field picks one of four modes
// - start/stop modes flag start, restart, stop
// - first byte compared with masked address
// - 7-bit compare ignores direction bit
// - 10-bit high byte pattern from address bits
// - update flag and stretch around 10-bit bytes
// - 10-bit read needs prior full match
// - write match clears rw, loads, acks
// - irq flag set per acked byte, software clears
// - stretch enable holds scl after bytes
// - start, stop bits and buffer read clear
// - msb first, sample on scl rise
// - start is sda falling while scl high
module isc_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire isc_pkg::isc_ctrl_t ctrl,
    input wire isc_pkg::isc_sw_t sw,
    output isc_pkg::isc_stat_t stat,
    output logic scl_o,
    output logic scl_oe_n,
    output logic sda_o,
    output logic sda_oe_n
);
    logic rst_s;
    logic [1:0] lines_s;
    isc_pkg::isc_cond_t ev;
    isc_pkg::isc_st_t st_r;
    isc_pkg::isc_st_t st_nxt;
    logic [7:0] b;
    logic ten;
    logic ss;
    logic hold_mode;
    logic blocked;
    logic hi_match;
    logic seven_match;
    logic lo_match;
    logic accept;
    logic active;
    logic byte_done;
    logic ninth_fall;

    // reset is released through two flops
    isc_sync #(.WIDTH(1), .RST_VAL(isc_pkg::RST_ASSERTED)) u_rst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(1'b1),
        .dout(rst_s)
    );

    // bus lines are asynchronous to clk
    isc_sync #(.WIDTH(2), .RST_VAL(isc_pkg::LINES_IDLE)) u_line_sync (
        .clk(clk),
        .rst_n(rst_s),
        .din({scl_i, sda_i}),
        .dout(lines_s)
    );

    isc_cond u_cond (
        .clk(clk),
        .rst_n(rst_s),
        .scl_s(lines_s[1]),
        .sda_s(lines_s[0]),
        .ev(ev)
    );

    // next state of the whole slave
    always_comb begin
        st_nxt = st_r;
        b = st_r.shreg;
        ten = ctrl.mode_select_field[isc_pkg::MODE_TEN_POS];
        ss = ctrl.mode_select_field[isc_pkg::MODE_SS_POS];
        hold_mode = (st_r.phase == isc_pkg::PH_DATA) ? ctrl.data_hold_enable
            : ctrl.address_hold_enable;
        // overwrite enable lets a full buffer take the byte, overflow still refuses
        blocked = ctrl.buffer_overwrite_enable ? st_r.stat.receive_overflow_flag
            : (st_r.stat.buffer_full_flag || st_r.stat.receive_overflow_flag);
        hi_match = (((b ^ {isc_pkg::HI10_PREFIX, ctrl.slave_address_reg[2:1], 1'b0})
            & ctrl.address_mask & isc_pkg::RW_IGNORE) == 8'h00);
        seven_match = (((b ^ ctrl.slave_address_reg) & ctrl.address_mask
            & isc_pkg::RW_IGNORE) == 8'h00);
        lo_match = (((b ^ ctrl.slave_address_reg) & ctrl.address_mask) == 8'h00);
        accept = 1'b0;
        active = (st_r.phase != isc_pkg::PH_IDLE) && !ev.start && !ev.stop;
        byte_done = active && ev.fall && (st_r.cnt == isc_pkg::LAST_DATA_BIT);
        ninth_fall = active && ev.fall && (st_r.cnt == isc_pkg::ACK_SLOT);

        // software clears come first so that a hardware set below wins
        if (sw.irq_clear) begin
            st_nxt.stat.port_interrupt_flag = 1'b0;
        end
        if (sw.buffer_read) begin
            st_nxt.stat.buffer_full_flag = 1'b0;
        end
        if (sw.overflow_clear) begin
            st_nxt.stat.receive_overflow_flag = 1'b0;
        end
        if (sw.clock_release_set) begin
            st_nxt.stat.clock_release_bit = 1'b1;
        end
        // rewriting the address ends the update wait and releases scl
        if (sw.address_write) begin
            st_nxt.stat.update_address_flag = 1'b0;
            if (st_r.stat.update_address_flag) begin
                st_nxt.stat.clock_release_bit = 1'b1;
            end
        end

        // while stretched in a hold, software may still change its answer
        if (st_r.soft_ack && (st_r.cnt == isc_pkg::ACK_SLOT)
            && !st_r.stat.clock_release_bit) begin
            st_nxt.ack_low = !ctrl.ack_data_bit && !st_r.forced_nack;
        end

        if (ev.start) begin
            // start and restart look the same here
            st_nxt.phase = isc_pkg::PH_ADDR_HI;
            // the start's own scl fall is not a data bit, so it must not be counted
            st_nxt.cnt = isc_pkg::CNT_AFTER_START;
            st_nxt.ack_low = 1'b0;
            st_nxt.soft_ack = 1'b0;
            st_nxt.stat.ack_time_status = 1'b0;
            st_nxt.stat.clock_release_bit = 1'b1;
            st_nxt.stat.start_seen = 1'b1;
            st_nxt.stat.stop_seen = 1'b0;
            if (ss || ctrl.start_irq_enable) begin
                st_nxt.stat.port_interrupt_flag = 1'b1;
            end
        end else if (ev.stop) begin
            st_nxt.phase = isc_pkg::PH_IDLE;
            st_nxt.cnt = 4'h0;
            st_nxt.ack_low = 1'b0;
            st_nxt.soft_ack = 1'b0;
            st_nxt.prior_match = 1'b0;
            st_nxt.stat.ack_time_status = 1'b0;
            st_nxt.stat.clock_release_bit = 1'b1;
            st_nxt.stat.stop_seen = 1'b1;
            st_nxt.stat.start_seen = 1'b0;
            if (ss || ctrl.stop_irq_enable) begin
                st_nxt.stat.port_interrupt_flag = 1'b1;
            end
        end else if (active && ev.rise) begin
            if (st_r.cnt < isc_pkg::ACK_SLOT) begin
                st_nxt.shreg = {st_r.shreg[6:0], lines_s[0]};
            end else if (st_r.cnt == isc_pkg::ACK_SLOT) begin
                st_nxt.stat.ack_status_bit = lines_s[0];
            end
        end

        if (byte_done) begin
            st_nxt.cnt = isc_pkg::ACK_SLOT;
            case (st_r.phase)
                isc_pkg::PH_ADDR_HI: begin
                    if (ten) begin
                        if (!hi_match) begin
                            st_nxt.prior_match = 1'b0;
                            st_nxt.phase = isc_pkg::PH_IDLE;
                        end else if (b[0] && !st_r.prior_match) begin
                            st_nxt.phase = isc_pkg::PH_IDLE;
                        end else begin
                            accept = 1'b1;
                            st_nxt.stat.rw_status = b[0];
                            if (!b[0]) begin
                                st_nxt.prior_match = 1'b0;
                            end
                            st_nxt.pend = b[0] ? isc_pkg::PH_READ
                                : isc_pkg::PH_ADDR_LO;
                        end
                    end else if (seven_match) begin
                        accept = 1'b1;
                        st_nxt.stat.rw_status = b[0];
                        st_nxt.pend = b[0] ? isc_pkg::PH_READ : isc_pkg::PH_DATA;
                    end else begin
                        st_nxt.phase = isc_pkg::PH_IDLE;
                    end
                end
                isc_pkg::PH_ADDR_LO: begin
                    // all eight low bits count, a miss still waits for the update
                    accept = lo_match;
                    st_nxt.prior_match = lo_match;
                    st_nxt.pend = lo_match ? isc_pkg::PH_DATA : isc_pkg::PH_IDLE;
                end
                isc_pkg::PH_DATA: begin
                    accept = 1'b1;
                    st_nxt.pend = isc_pkg::PH_DATA;
                end
                isc_pkg::PH_READ: begin
                    st_nxt.pend = isc_pkg::PH_READ;
                end
                default: begin
                    st_nxt.phase = isc_pkg::PH_IDLE;
                end
            endcase
            if (st_nxt.phase == isc_pkg::PH_IDLE) begin
                st_nxt.cnt = 4'h0;
            end
        end else if (ninth_fall) begin
            st_nxt.cnt = 4'h0;
            st_nxt.ack_low = 1'b0;
            st_nxt.soft_ack = 1'b0;
            st_nxt.stat.ack_time_status = 1'b0;
            if (st_r.ack_low) begin
                // every acknowledged byte raises the flag
                st_nxt.stat.port_interrupt_flag = 1'b1;
                if (st_r.pend == isc_pkg::PH_ADDR_LO) begin
                    st_nxt.stat.update_address_flag = 1'b1;
                    st_nxt.stat.clock_release_bit = 1'b0;
                end else if (st_r.pend == isc_pkg::PH_READ) begin
                    st_nxt.stat.clock_release_bit = 1'b0;
                end else if (ctrl.stretch_enable) begin
                    st_nxt.stat.clock_release_bit = 1'b0;
                end
            end
            if (st_r.phase == isc_pkg::PH_ADDR_LO) begin
                st_nxt.stat.port_interrupt_flag = 1'b1;
                st_nxt.stat.update_address_flag = 1'b1;
                st_nxt.stat.clock_release_bit = 1'b0;
            end
            if (st_r.phase == isc_pkg::PH_READ) begin
                // master ack asks for more data: hold scl, else drop out
                st_nxt.phase = st_r.stat.ack_status_bit ? isc_pkg::PH_IDLE
                    : isc_pkg::PH_READ;
                st_nxt.stat.port_interrupt_flag = 1'b1;
                if (!st_r.stat.ack_status_bit) begin
                    st_nxt.stat.clock_release_bit = 1'b0;
                end
            end else if (st_r.ack_low) begin
                st_nxt.phase = st_r.pend;
            end else if (st_r.phase != isc_pkg::PH_DATA) begin
                st_nxt.phase = isc_pkg::PH_IDLE;
            end
        end else if (active && ev.fall) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end

        // an accepted byte is loaded unless blocked, then acked or nacked by hardware or software
        if (accept) begin
            if (!blocked) begin
                st_nxt.stat.receive_buffer = b;
                st_nxt.stat.buffer_full_flag = 1'b1;
            end else if (st_r.stat.buffer_full_flag) begin
                st_nxt.stat.receive_overflow_flag = 1'b1;
            end
            st_nxt.forced_nack = blocked;
            if (hold_mode) begin
                st_nxt.soft_ack = 1'b1;
                st_nxt.ack_low = !ctrl.ack_data_bit && !blocked;
                st_nxt.stat.ack_time_status = 1'b1;
                st_nxt.stat.port_interrupt_flag = 1'b1;
                st_nxt.stat.clock_release_bit = 1'b0;
            end else begin
                st_nxt.ack_low = !blocked;
            end
        end

        // open-drain drive: only ever pull low, enable is active low
        st_nxt.sda_oe_n = !(st_nxt.ack_low && (st_nxt.cnt == isc_pkg::ACK_SLOT));
        st_nxt.scl_oe_n = st_nxt.stat.clock_release_bit;
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            st_r <= isc_pkg::ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stat = st_r.stat;
    assign scl_oe_n = st_r.scl_oe_n;
    assign sda_oe_n = st_r.sda_oe_n;
    // driven level is always low; kept as plain outputs for the pad
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_s);

    sequence s_ninth_fall;
        ev.fall && (st_r.cnt == isc_pkg::ACK_SLOT) && (st_r.phase != isc_pkg::PH_IDLE);
    endsequence

    sequence s_low_byte_end;
        s_ninth_fall ##0 (st_r.phase == isc_pkg::PH_ADDR_LO);
    endsequence

    AST_START_RESETS: assert property (
        ev.start |=> (st_r.phase == isc_pkg::PH_ADDR_HI)
            && (st_r.cnt == isc_pkg::CNT_AFTER_START)
            && st_r.stat.start_seen && st_r.sda_oe_n)
        else $error("start did not reset the slave");

    AST_STOP_IDLE: assert property (
        ev.stop |=> (st_r.phase == isc_pkg::PH_IDLE) && st_r.stat.stop_seen
            && !st_r.prior_match && !st_r.stat.start_seen)
        else $error("stop did not return to idle");

    AST_SS_IRQ: assert property (
        ev.start && ctrl.mode_select_field[isc_pkg::MODE_SS_POS]
            |=> st_r.stat.port_interrupt_flag)
        else $error("start in start/stop mode missed the irq");

    AST_SDA_ACK_ONLY: assert property (
        !st_r.sda_oe_n |-> (st_r.cnt == isc_pkg::ACK_SLOT) && st_r.ack_low)
        else $error("sda pulled outside the ack slot");

    AST_ACK_TIME_STATUS_HOLD: assert property (
        $rose(st_r.stat.ack_time_status)
            |-> $past(ctrl.address_hold_enable || ctrl.data_hold_enable)
            && (st_r.cnt == isc_pkg::ACK_SLOT))
        else $error("ack time set without hold enable");

    AST_IRQ_STICKY: assert property (
        st_r.stat.port_interrupt_flag && !sw.irq_clear |=> st_r.stat.port_interrupt_flag)
        else $error("irq flag dropped without a clear");

    AST_FULL_NACK: assert property (
        byte_done && st_r.stat.buffer_full_flag && !ctrl.buffer_overwrite_enable
            |=> !st_r.ack_low && st_r.sda_oe_n)
        else $error("byte acked while buffer full");

    AST_STRETCH_KEEP: assert property (
        !st_r.stat.clock_release_bit && !sw.clock_release_set && !sw.address_write
            && !ev.start && !ev.stop |=> !st_r.stat.clock_release_bit && !st_r.scl_oe_n)
        else $error("scl released without software");

    AST_UA_LOW_BYTE: assert property (
        s_low_byte_end |=> st_r.stat.update_address_flag && !st_r.stat.clock_release_bit
            && st_r.stat.port_interrupt_flag)
        else $error("low byte end missed update flag or stretch");

    AST_ACK_STATUS_BIT: assert property (
        ev.rise && (st_r.cnt == isc_pkg::ACK_SLOT) && (st_r.phase != isc_pkg::PH_IDLE)
            |=> st_r.stat.ack_status_bit == $past(lines_s[0]))
        else $error("ack status not captured");
endmodule : isc_slave
`default_nettype wire

//--- testbench/isc_master.sv
// Purpose: behavioural i2c bus master for the slave front end
// Assumes: both lines have pull-ups, drivers are open drain
// Notes: waits on scl after release, so slave stretching is honoured
`timescale 1ns/1ps
`default_nettype none
module isc_master (
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe_n,
    output logic sda_oe_n
);
    parameter real Q = 31.25;
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
    end
    // one scl pulse; sda sampled mid high time
    task automatic pulse(output logic b);
        #Q scl_oe_n = 1'b1;
        wait (scl === 1'b1);
        #Q b = sda;
        #Q scl_oe_n = 1'b0;
        #Q;
    endtask : pulse
    // also serves as restart, sda released while scl low
    task automatic start();
        sda_oe_n = 1'b1;
        #Q scl_oe_n = 1'b1;
        wait (scl === 1'b1);
        #Q sda_oe_n = 1'b0;
        #Q scl_oe_n = 1'b0;
        #Q;
    endtask : start
    task automatic stop();
        sda_oe_n = 1'b0;
        #Q scl_oe_n = 1'b1;
        wait (scl === 1'b1);
        #Q sda_oe_n = 1'b1;
        #(2 * Q);
    endtask : stop
    // eight bits msb first, then release sda for the ack slot
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            sda_oe_n = d[i];
            pulse(b);
        end
        sda_oe_n = 1'b1;
        pulse(ack);
    endtask : send
endmodule : isc_master
`default_nettype wire

//--- testbench/isc_slave_tb.sv
// Purpose: self-checking bench of the i2c slave front end
// Assumes: master model drives the bus, bench drives ctrl and sw
// Notes: stat is judged some cycles after each bus step settles
`timescale 1ns/1ps
`default_nettype none
module isc_slave_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire scl;
    wire sda;
    logic m_scl_oe_n;
    logic m_sda_oe_n;
    logic scl_oe_n;
    logic sda_oe_n;
    logic ack;
    isc_pkg::isc_ctrl_t ctrl;
    isc_pkg::isc_sw_t sw;
    isc_pkg::isc_stat_t stat;
    int n_errors = 0;
    int checked = 0;
    always #5 clk = ~clk;
    // pulled-up wires, low when any party pulls
    assign scl = m_scl_oe_n & scl_oe_n;
    assign sda = m_sda_oe_n & sda_oe_n;
    isc_master m (.scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n), .sda_oe_n(m_sda_oe_n));
    isc_slave dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .ctrl(ctrl),
        .sw(sw), .stat(stat), .scl_o(), .scl_oe_n(scl_oe_n), .sda_o(),
        .sda_oe_n(sda_oe_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // sw bits: 10 irq clear, 08 buffer read, 04 overflow clear, 02 release
    task automatic pulse_sw(input isc_pkg::isc_sw_t p);
        @(posedge clk) #1 sw = p;
        @(posedge clk) #1 sw = '0;
    endtask : pulse_sw
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask : settle
    // every mode, with and without the start irq enable
    task automatic t_modes();
        for (int i = 0; i < 8; i++) begin
            ctrl.mode_select_field = 2'(i);
            ctrl.start_irq_enable = i[2];
            ctrl.stop_irq_enable = i[2];
            pulse_sw(5'h10);
            m.start();
            settle();
            chk(stat.port_interrupt_flag, i[1] | i[2]);
            pulse_sw(5'h10);
            m.stop();
            settle();
            chk(stat.port_interrupt_flag, i[1] | i[2]);
        end
        ctrl.mode_select_field = 2'h0;
        ctrl.start_irq_enable = 1'b0;
        ctrl.stop_irq_enable = 1'b0;
        $display("modes test done");
    endtask : t_modes
    // matched write, then a byte into a full buffer
    task automatic t_write();
        pulse_sw(5'h10);
        m.start();
        m.send(8'hA0, ack);
        settle();
        chk(ack, 1'b0);
        chk(stat.receive_buffer, 8'hA0);
        chk(stat.rw_status, 1'b0);
        chk(stat.port_interrupt_flag, 1'b1);
        chk(stat.start_seen, 1'b1);
        chk(stat.ack_time_status, 1'b0);
        pulse_sw(5'h10);
        m.send(8'h3C, ack);
        settle();
        chk(ack, 1'b1);
        chk(stat.ack_status_bit, 1'b1);
        chk(stat.receive_overflow_flag, 1'b1);
        chk(stat.receive_buffer, 8'hA0);
        chk(stat.port_interrupt_flag, 1'b0);
        m.stop();
        settle();
        chk(stat.stop_seen, 1'b1);
        pulse_sw(5'h0C);
        settle();
        chk(stat.buffer_full_flag, 1'b0);
        chk(stat.receive_overflow_flag, 1'b0);
        $display("write test done");
    endtask : t_write
    // mismatch goes idle silently, restart with read bit still matches
    task automatic t_read();
        m.start();
        m.send(8'hA2, ack);
        settle();
        chk(ack, 1'b1);
        chk(stat.port_interrupt_flag, 1'b0);
        m.start();
        m.send(8'hA1, ack);
        settle();
        chk(ack, 1'b0);
        chk(stat.rw_status, 1'b1);
        pulse_sw(5'h12);
        m.stop();
        settle();
        $display("read test done");
    endtask : t_read
    // hold mode, software answers with a nack
    task automatic t_hold();
        pulse_sw(5'h18);
        ctrl.address_hold_enable = 1'b1;
        ctrl.ack_data_bit = 1'b1;
        m.start();
        fork
            m.send(8'hA0, ack);
            begin
                wait (stat.ack_time_status === 1'b1);
                settle();
                chk(scl_oe_n, 1'b0);
                pulse_sw(5'h02);
            end
        join
        settle();
        chk(ack, 1'b1);
        m.stop();
        settle();
        $display("hold test done");
    endtask : t_hold
    // 10-bit: read refused without prior match, then full match and read
    task automatic t_ten();
        ctrl.address_hold_enable = 1'b0;
        ctrl.ack_data_bit = 1'b0;
        ctrl.mode_select_field = 2'h1;
        ctrl.slave_address_reg = 8'h04;
        pulse_sw(5'h18);
        m.start();
        m.send(8'hF5, ack);
        settle();
        chk(ack, 1'b1);
        m.start();
        m.send(8'hF4, ack);
        chk(ack, 1'b0);
        fork
            m.send(8'hA5, ack);
            begin
                settle();
                chk(stat.update_address_flag, 1'b1);
                chk(scl_oe_n, 1'b0);
                ctrl.slave_address_reg = 8'hA5;
                pulse_sw(5'h19);
            end
        join
        chk(ack, 1'b0);
        fork
            m.start();
            begin
                settle();
                chk(stat.update_address_flag, 1'b1);
                chk(stat.port_interrupt_flag, 1'b1);
                ctrl.slave_address_reg = 8'h04;
                pulse_sw(5'h19);
            end
        join
        m.send(8'hF5, ack);
        settle();
        chk(ack, 1'b0);
        chk(stat.rw_status, 1'b1);
        chk(scl_oe_n, 1'b0);
        pulse_sw(5'h12);
        m.stop();
        settle();
        ctrl.mode_select_field = 2'h0;
        $display("ten-bit test done");
    endtask : t_ten
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        ctrl = '0;
        ctrl.slave_address_reg = 8'hA0;
        ctrl.address_mask = 8'hFF;
        sw = '0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        t_modes();
        t_write();
        t_read();
        t_hold();
        t_ten();
        final_report();
    end
    // cuts a hang on a stuck scl or flag
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
endmodule : isc_slave_tb
`default_nettype wire
